// ### logic/jk_sequencer.sv
// programmable AND/OR sequencer with four J-K registers and eight bidirectional lines
// assumes all pins synchronous to SYS_CLK; link map is loaded over an Avalon-MM slave
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.

// Operation
// - four dedicated inputs, four registered pins, eight bidirectional lines.
// - thirty-two logic terms, thirteen control terms, twenty-one sum terms, all programmable.
// - every term takes inputs, lines, states and complement, true or inverted.
// - complement is NOR of linked terms and feeds every term.
// - each line driven through XOR stage giving AND-OR or AND-NOR.
// - any logic term may reach J and K of each flip-flop.
// - fold-back control makes a J-K flip-flop D-type; toggle stays possible.
// - preset and reset from sum terms, overriding clocked inputs.
// - flip-flops change only on rising edge; load control and output select.
// - high-voltage enable loads flip-flops from pins, lines floated.
// - unprogrammed part keeps output enable asserted.
// - unprogrammed part never presets or resets.
// - unprogrammed part has every transition term inactive.
// - unprogrammed flip-flops run in D mode unless programmed otherwise.
// - unprogrammed lines are inputs, registered pins outputs.
module jk_sequencer (
    // clock, reset, enable
    input  wire logic        SYS_CLK,
    input  wire logic        RST_B,
    input  wire logic        CLK_EN,
    // register bus
    input  wire logic [9:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output      logic [31:0] AVS_READDATA,
    output      logic        AVS_WAITREQUEST,
    // dedicated inputs and enable pins
    input  wire logic [3:0]  DIN,
    input  wire logic        OE_B,
    input  wire logic        OE_HV,
    // bidirectional lines
    input  wire logic [7:0]  BIO_IN,
    output      logic [7:0]  BIO_OUT,
    output      logic [7:0]  BIO_OE,
    // registered pins
    input  wire logic [3:0]  FREG_IN,
    output      logic [3:0]  FREG_OUT,
    output      logic [3:0]  FREG_OE
);

    ////////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic                                            wait_req;
        logic [31:0]                                     rdata;
        logic [seq_pkg::N_FF-1:0]                        q;
        logic [seq_pkg::N_BIO-1:0]                       b_out;
        logic [seq_pkg::N_BIO-1:0]                       b_oe;
        logic [seq_pkg::N_FF-1:0]                        f_out;
        logic [seq_pkg::N_FF-1:0]                        f_oe;
        logic [seq_pkg::N_BIO-1:0]                       b_pol;
        logic [seq_pkg::N_FF-1:0]                        f_sel;
        logic [2*seq_pkg::N_FF-1:0]                      ff_mode;
        logic [seq_pkg::N_LOGIC-1:0]                     c_link;
        logic [seq_pkg::N_SUMS-1:0][seq_pkg::N_LOGIC-1:0] sum_link;
        logic [seq_pkg::N_TERMS-1:0][seq_pkg::MASK_W-1:0] tmask;
        logic [seq_pkg::N_TERMS-1:0][seq_pkg::MASK_W-1:0] cmask;
    } state_t;

    localparam state_t ST_RST = '{
        wait_req: 1'b1,
        rdata:    32'h0,
        q:        seq_pkg::Q_RST,
        b_out:    8'h00,
        b_oe:     8'h00,
        f_out:    ~seq_pkg::Q_RST,
        f_oe:     4'h0,
        b_pol:    seq_pkg::POL_RST,
        f_sel:    seq_pkg::FSEL_RST,
        ff_mode:  seq_pkg::MODE_RST,
        c_link:   seq_pkg::CLINK_RST,
        sum_link: {seq_pkg::N_SUMS{seq_pkg::SUM_RST}},
        tmask:    {seq_pkg::N_TERMS{seq_pkg::MASK_RST}},
        cmask:    {seq_pkg::N_TERMS{seq_pkg::MASK_RST}}
    };

    state_t                          s_q;
    state_t                          s_d;
    logic [seq_pkg::TERM_IN-1:0]     term_vec;
    logic [seq_pkg::N_TERMS-1:0]     pt_noc;
    logic [seq_pkg::N_TERMS-1:0]     pt;
    logic [seq_pkg::N_SUMS-1:0]      sum;
    logic                            c_out;
    logic [31:0]                     rd_word;
    logic [31:0]                     wr_word;
    logic [9:0]                      sum_ofs;
    logic [9:0]                      term_ofs;
    logic [7:0]                      sum_idx;
    logic [7:0]                      term_idx;
    logic                            sum_hit;
    logic                            term_hit;

    function automatic logic [31:0] be_merge(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[8*i +: 8] = new_w[8*i +: 8];
        end
        return r;
    endfunction : be_merge

    ////////////////////////////////////////////////////////////////////////////////
    // AND array
    // term inputs
    assign term_vec = {s_q.q, BIO_IN, DIN};

    // complement NOR
    // terms that feed the NOR see it without their own complement link, which breaks the loop
    assign c_out = ~|(pt_noc[seq_pkg::N_LOGIC-1:0] & s_q.c_link);

    genvar g;
    generate
        for (g = 0; g < seq_pkg::N_TERMS; g++)
        begin : g_term
            pterm #(
                .WIDTH (seq_pkg::TERM_IN)
            ) u_term (
                .term_in  (term_vec),
                .true_sel (s_q.tmask[g][seq_pkg::TERM_IN-1:0]),
                .comp_sel (s_q.cmask[g][seq_pkg::TERM_IN-1:0]),
                .term_out (pt_noc[g])
            );
            assign pt[g] = pt_noc[g] & (~s_q.tmask[g][seq_pkg::C_BIT] | c_out)
                                     & (~s_q.cmask[g][seq_pkg::C_BIT] | ~c_out);
        end
        for (g = 0; g < seq_pkg::N_SUMS; g++)
        begin : g_sum
            assign sum[g] = |(pt[seq_pkg::N_LOGIC-1:0] & s_q.sum_link[g]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // register decode
    assign sum_ofs  = AVS_ADDRESS - seq_pkg::SUM_BASE;
    assign term_ofs = AVS_ADDRESS - seq_pkg::TERM_BASE;
    assign sum_idx  = {2'h0, sum_ofs[7:2]};
    assign term_idx = term_ofs[9:2];
    // sum slots past the last sum read zero and ignore writes
    assign sum_hit  = (AVS_ADDRESS >= seq_pkg::SUM_BASE) && (AVS_ADDRESS < seq_pkg::TERM_BASE)
                      && (sum_ofs[9:8] == 2'h0) && (sum_idx < 8'(seq_pkg::N_SUMS));
    assign term_hit = (AVS_ADDRESS >= seq_pkg::TERM_BASE) && (term_idx < 8'(2 * seq_pkg::N_TERMS));

    always_comb
    begin
        rd_word = 32'h0;
        if (AVS_ADDRESS[9:2] == seq_pkg::CFG_OFS[9:2])
            rd_word = {12'h0, s_q.ff_mode, s_q.f_sel, s_q.b_pol};
        else if (AVS_ADDRESS[9:2] == seq_pkg::CLINK_OFS[9:2])
            rd_word = s_q.c_link;
        else if (AVS_ADDRESS[9:2] == seq_pkg::STATE_OFS[9:2])
            rd_word = {15'h0, c_out, FREG_IN, BIO_IN, s_q.q};
        else if (sum_hit)
            rd_word = s_q.sum_link[sum_idx[4:0]];
        else if (term_hit && term_idx[0])
            rd_word = {15'h0, s_q.cmask[term_idx[6:1]]};
        else if (term_hit)
            rd_word = {15'h0, s_q.tmask[term_idx[6:1]]};
    end

    // unenabled lanes keep the stored bits of the addressed word
    assign wr_word = be_merge(rd_word, AVS_WRITEDATA, AVS_BYTEENABLE);

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        logic [1:0] mode;
        logic       fold;
        logic       j_in;
        logic       k_in;
        logic       pre;
        logic       clr;
        mode = 2'h0;
        fold = 1'b0;
        j_in = 1'b0;
        k_in = 1'b0;
        pre  = 1'b0;
        clr  = 1'b0;
        s_d  = s_q;

        // bus slave: one wait cycle, then a single low waitrequest cycle
        s_d.wait_req = 1'b1;
        if ((AVS_READ || AVS_WRITE) && s_q.wait_req)
        begin
            s_d.wait_req = 1'b0;
            s_d.rdata    = rd_word;
            if (AVS_WRITE)
            begin
                if (AVS_ADDRESS[9:2] == seq_pkg::CFG_OFS[9:2])
                begin
                    s_d.b_pol   = wr_word[seq_pkg::CFG_POL_LSB +: 8];
                    s_d.f_sel   = wr_word[seq_pkg::CFG_FSEL_LSB +: 4];
                    s_d.ff_mode = wr_word[seq_pkg::CFG_MODE_LSB +: 8];
                end
                else if (AVS_ADDRESS[9:2] == seq_pkg::CLINK_OFS[9:2])
                    s_d.c_link = wr_word;
                else if (sum_hit)
                    s_d.sum_link[sum_idx[4:0]] = wr_word;
                else if (term_hit && term_idx[0])
                    s_d.cmask[term_idx[6:1]] = wr_word[seq_pkg::MASK_W-1:0];
                else if (term_hit)
                    s_d.tmask[term_idx[6:1]] = wr_word[seq_pkg::MASK_W-1:0];
            end
        end

        for (int f = 0; f < seq_pkg::N_FF; f++)
        begin
            mode = s_q.ff_mode[2*f +: 2];
            // D mode, J-K only, or controlled
            // fold-back feeds inverted J to K
            case (mode)
                seq_pkg::MODE_D:    fold = 1'b1;
                seq_pkg::MODE_CTRL: fold = pt[seq_pkg::FOLD_TERM];
                default:            fold = 1'b0;
            endcase
            j_in = sum[seq_pkg::SUM_J0 + f];
            k_in = fold ? ~j_in : sum[seq_pkg::SUM_K0 + f];
            // preset and reset act at the edge, a clocked image of the async pair
            // preset and reset pairs
            pre  = sum[seq_pkg::SUM_PRE0 + f/2];
            clr  = sum[seq_pkg::SUM_RST0 + f/2];
            if (OE_HV)
                s_d.q[f] = ~FREG_IN[f];
            else if (pre)
                s_d.q[f] = 1'b1;
            else if (clr)
                s_d.q[f] = 1'b0;
            else if (pt[seq_pkg::LOAD_TERM0 + f])
                s_d.q[f] = ~FREG_IN[f];
            else
            begin
                case ({j_in, k_in})
                    2'b01:   s_d.q[f] = 1'b0;
                    2'b10:   s_d.q[f] = 1'b1;
                    2'b11:   s_d.q[f] = ~s_q.q[f];
                    default: s_d.q[f] = s_q.q[f];
                endcase
            end
            s_d.f_out[f] = ~s_d.q[f];
            // enabled when selected, unless pin or sum disables
            s_d.f_oe[f]  = ~OE_B && ~OE_HV && s_q.f_sel[f] && ~sum[seq_pkg::SUM_FDIS];
        end

        for (int b = 0; b < seq_pkg::N_BIO; b++)
        begin
            s_d.b_out[b] = sum[seq_pkg::SUM_B0 + b] ^ s_q.b_pol[b];
            s_d.b_oe[b]  = pt[seq_pkg::DIR_TERM0 + b] && ~OE_HV;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    // a low enable freezes every register, bus slave included
    // pin groups
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            s_q <= ST_RST;
        else if (CLK_EN)
            s_q <= s_d;
    end

    assign AVS_READDATA    = s_q.rdata;
    assign AVS_WAITREQUEST = s_q.wait_req;
    assign BIO_OUT         = s_q.b_out;
    assign BIO_OE          = s_q.b_oe;
    assign FREG_OUT        = s_q.f_out;
    assign FREG_OE         = s_q.f_oe;

endmodule : jk_sequencer

// ### logic/seq_pkg.sv
// constants for the programmable J-K logic sequencer: register map, fuse layout, reset values
// assumes a byte-addressed 32-bit register bus and pins sampled on the system clock
package seq_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // array shape
    localparam int N_DIN      = 4;
    localparam int N_BIO      = 8;
    localparam int N_FF       = 4;
    localparam int N_LOGIC    = 32;
    localparam int N_CTRL     = 13;
    localparam int N_TERMS    = 45;
    localparam int N_SUMS     = 21;
    localparam int TERM_IN    = 16;
    localparam int MASK_W     = 17;
    localparam int C_BIT      = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // control term indices
    localparam int FOLD_TERM  = 32;
    localparam int LOAD_TERM0 = 33;
    localparam int DIR_TERM0  = 37;

    ////////////////////////////////////////////////////////////////////////////////
    // sum term indices
    localparam int SUM_B0     = 0;
    localparam int SUM_J0     = 8;
    localparam int SUM_K0     = 12;
    localparam int SUM_PRE0   = 16;
    localparam int SUM_RST0   = 18;
    localparam int SUM_FDIS   = 20;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [9:0] CFG_OFS   = 10'h000;
    localparam logic [9:0] CLINK_OFS = 10'h004;
    localparam logic [9:0] STATE_OFS = 10'h008;
    localparam logic [9:0] SUM_BASE  = 10'h100;
    localparam logic [9:0] TERM_BASE = 10'h200;

    // configuration word fields
    localparam int CFG_POL_LSB  = 0;
    localparam int CFG_FSEL_LSB = 8;
    localparam int CFG_MODE_LSB = 12;

    ////////////////////////////////////////////////////////////////////////////////
    // flip-flop modes, two bits per flip-flop
    localparam logic [1:0] MODE_JK   = 2'h1;
    localparam logic [1:0] MODE_CTRL = 2'h2;
    localparam logic [1:0] MODE_D    = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values: every link intact, as shipped
    localparam logic [7:0]  POL_RST   = 8'h00;
    localparam logic [3:0]  FSEL_RST  = 4'hf;
    localparam logic [7:0]  MODE_RST  = 8'hff;
    localparam logic [31:0] CLINK_RST = 32'hffffffff;
    localparam logic [31:0] SUM_RST   = 32'hffffffff;
    localparam logic [16:0] MASK_RST  = 17'h1ffff;
    localparam logic [3:0]  Q_RST     = 4'h0;

endpackage : seq_pkg

// ### logic/pterm.sv
// one programmable AND term: each input may be linked in true and/or complement polarity
// assumes masks are held stable by the caller; a term with both links of one input is always low
module pterm #(
    parameter int WIDTH = 16
) (
    // term inputs
    input  wire logic [WIDTH-1:0] term_in,
    // link selections
    input  wire logic [WIDTH-1:0] true_sel,
    input  wire logic [WIDTH-1:0] comp_sel,
    // product
    output      logic             term_out
);

    assign term_out = &((term_in | ~true_sel) & (~term_in | ~comp_sel));

endmodule : pterm

// ### testbench/sys_logic_model.sv
// far-side system logic: resolves each shared pin from both parties' enables
// assumes the bench sets what the far side drives and when
module sys_logic_model (
    // registered pins
    input  wire logic [3:0] freg_out,
    input  wire logic [3:0] freg_oe,
    input  wire logic [3:0] f_drv,
    input  wire logic [3:0] f_en,
    output      logic [3:0] freg_in,
    // bidirectional lines
    input  wire logic [7:0] bio_out,
    input  wire logic [7:0] bio_oe,
    input  wire logic [7:0] b_drv,
    input  wire logic [7:0] b_en,
    output      logic [7:0] bio_in
);
    timeunit 1ns;
    timeprecision 100ps;
    assign freg_in = (freg_oe & freg_out) | (~freg_oe & f_en & f_drv) | (~freg_oe & ~f_en & ~freg_out);
    // released lines show the inverse level, never a stale one
    assign bio_in = (bio_oe & bio_out) | (~bio_oe & b_en & b_drv) | (~bio_oe & ~b_en & ~bio_out);
endmodule : sys_logic_model

// ### testbench/jk_sequencer_chk.sv
// assertions on the bus handshake and pin timing of the sequencer
// assumes one clock domain; bound to the design top
module jk_sequencer_chk (
    // clock, reset, enable
    input wire logic        SYS_CLK,
    input wire logic        RST_B,
    input wire logic        CLK_EN,
    // register bus
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    // pins
    input wire logic        OE_B,
    input wire logic        OE_HV,
    input wire logic [7:0]  BIO_OUT,
    input wire logic [7:0]  BIO_OE,
    input wire logic [3:0]  FREG_IN,
    input wire logic [3:0]  FREG_OUT,
    input wire logic [3:0]  FREG_OE
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);
    ////////////////////////////////
    property p_take; CLK_EN && (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
    a_take: assert property (p_take) else $error("access not answered next cycle");
    property p_one; CLK_EN && !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
    a_one: assert property (p_one) else $error("waitrequest low too long");
    property p_idle; CLK_EN && AVS_WAITREQUEST && !(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_hold; CLK_EN && !(AVS_READ || AVS_WRITE) |=> $stable(AVS_READDATA); endproperty
    a_hold: assert property (p_hold) else $error("read data moved while idle");
    property p_off; CLK_EN && OE_B |=> FREG_OE == 4'h0; endproperty
    a_off: assert property (p_off) else $error("registered pins driven while disabled");
    property p_hv_ld; CLK_EN && OE_HV |=> FREG_OUT == $past(FREG_IN); endproperty
    a_hv_ld: assert property (p_hv_ld) else $error("diagnostic load missed");
    property p_hv_z; CLK_EN && OE_HV |=> BIO_OE == 8'h00; endproperty
    a_hv_z: assert property (p_hv_z) else $error("lines driven in diagnostic mode");
    property p_frz; !CLK_EN |=> $stable(FREG_OUT) && $stable(BIO_OUT) && $stable(FREG_OE); endproperty
    a_frz: assert property (p_frz) else $error("state moved without an enabled edge");
    c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
    c_hv: cover property (OE_HV ##1 !OE_HV);
    c_off: cover property (OE_B && FREG_OE == 4'h0);
endmodule : jk_sequencer_chk

bind jk_sequencer jk_sequencer_chk u_chk (
    .SYS_CLK, .RST_B, .CLK_EN, .AVS_READ, .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST,
    .OE_B, .OE_HV, .BIO_OUT, .BIO_OE, .FREG_IN, .FREG_OUT, .FREG_OE
);

// ### testbench/test_programmable_jk_logic_sequencer.sv
// self-checking bench: register bus, J-K table, preset/reset, preload, lines
// assumes the far-side model resolves every shared pin
module test_programmable_jk_logic_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        clk_en = 1'b1;
    logic [9:0]  adr = 10'h000;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [3:0]  be = 4'hf;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata;
    logic        waitreq;
    logic [3:0]  din = 4'h0;
    logic        oe_b = 1'b0;
    logic        oe_hv = 1'b0;
    logic [7:0]  bio_in, bio_out, bio_oe;
    logic [3:0]  freg_in, freg_out, freg_oe;
    logic [3:0]  f_drv = 4'h0;
    logic [3:0]  f_en = 4'h0;
    logic [7:0]  b_drv = 8'h00;
    logic [7:0]  b_en = 8'hff;
    int          errors = 0;
    int          comparisons = 0;
    // inputs and expected pins per J-K step
    localparam logic [35:0] DV = 36'hc94212033;
    localparam logic [35:0] EV = 36'hcfcfefeef;

    jk_sequencer u_dut (
        .SYS_CLK(clk), .RST_B(rst_b), .CLK_EN(clk_en), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .DIN(din), .OE_B(oe_b), .OE_HV(oe_hv), .BIO_IN(bio_in),
        .BIO_OUT(bio_out), .BIO_OE(bio_oe), .FREG_IN(freg_in), .FREG_OUT(freg_out), .FREG_OE(freg_oe)
    );
    sys_logic_model u_far (
        .freg_out, .freg_oe, .f_drv, .f_en, .freg_in, .bio_out, .bio_oe, .b_drv, .b_en, .bio_in
    );

    initial
        forever #12.5 clk = ~clk;
    ////////////////////////////////
    task automatic wrap_up();
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask : chk

    // one access; waits for waitrequest low, then releases and idles an edge
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitreq !== 1'b0 && n < 50);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50)
        begin
            errors++;
            $display("Error at %0t: bus access not answered", $time);
        end
        @(posedge clk);
    endtask : bus

    task automatic wreg(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wreg

    task automatic rchk(input logic [9:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rchk
    ////////////////////////////////
    initial
    begin
        #50us;
        errors++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        chk(freg_oe, 4'hf); // pins enabled
        chk(freg_out, 4'hf); // state clear
        chk(bio_oe, 8'h00); // lines are inputs
        rchk(seq_pkg::CFG_OFS, 32'h000fff00); // d mode
        rchk(seq_pkg::CLINK_OFS, 32'hffffffff); // links intact
        rchk(seq_pkg::SUM_BASE + 10'h050, 32'hffffffff); // sum links
        rchk(seq_pkg::TERM_BASE + 10'h164, 32'h0001ffff); // term links
        wreg(seq_pkg::STATE_OFS, 32'h0);
        rchk(seq_pkg::STATE_OFS, 32'h0001f000); // status word
        wreg(10'h3fc, 32'hffffffff);
        rchk(10'h3fc, 32'h0); // unmapped slot reads zero
        for (int k = 0; k < 21; k++)
            wreg(seq_pkg::SUM_BASE + 10'(4 * k), 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            wreg(seq_pkg::TERM_BASE + 10'(8 * i), 32'h1 << i);
            wreg(seq_pkg::TERM_BASE + 10'(8 * i + 4), 32'h0);
        end
        wreg(seq_pkg::SUM_BASE + 10'h020, 32'h1);
        wreg(seq_pkg::SUM_BASE + 10'h030, 32'h2);
        wreg(seq_pkg::SUM_BASE + 10'h040, 32'h4);
        wreg(seq_pkg::SUM_BASE + 10'h048, 32'h8);
        wreg(seq_pkg::CFG_OFS, 32'h000fdf00);
        din <= 4'h1;
        @(posedge clk);
        rchk(seq_pkg::STATE_OFS, 32'h0000e001); // set and nor
        for (int s = 0; s < 9; s++)
        begin
            din <= DV[4*s+:4];
            @(posedge clk);
            din <= 4'h0;
            @(posedge clk);
            chk(freg_out, EV[4*s+:4]); // step result
        end
        oe_b <= 1'b1;
        f_en <= 4'hf;
        f_drv <= 4'h1;
        repeat (2) @(posedge clk);
        chk(freg_oe, 4'h0); // pins float
        wreg(seq_pkg::TERM_BASE + 10'h108, 32'h10);
        wreg(seq_pkg::TERM_BASE + 10'h10c, 32'h0);
        b_drv <= 8'h01;
        repeat (2) @(posedge clk);
        chk(freg_out, 4'hf); // preload
        b_drv <= 8'h00;
        oe_hv <= 1'b1;
        f_drv <= 4'ha;
        repeat (2) @(posedge clk);
        chk(freg_out, 4'ha); // diagnostic load
        chk(bio_oe, 8'h00); // lines float
        oe_hv <= 1'b0;
        wreg(seq_pkg::CFG_OFS, 32'h000fef00);
        wreg(seq_pkg::TERM_BASE + 10'h100, 32'h40);
        wreg(seq_pkg::TERM_BASE + 10'h104, 32'h0);
        chk(freg_out, 4'he); // fold-back off holds
        b_drv <= 8'h04;
        repeat (2) @(posedge clk);
        chk(freg_out, 4'hf); // fold-back on loads d
        wreg(seq_pkg::TERM_BASE + 10'h130, 32'h0);
        wreg(seq_pkg::TERM_BASE + 10'h134, 32'h0);
        wreg(seq_pkg::SUM_BASE + 10'h004, 32'h1);
        din <= 4'h1;
        repeat (2) @(posedge clk);
        chk(bio_oe, 8'h02); // line direction
        chk(bio_out, 8'h02); // and-or
        be <= 4'h1;
        wreg(seq_pkg::CFG_OFS, 32'hffffff02);
        be <= 4'hf;
        repeat (2) @(posedge clk);
        chk(bio_out, 8'h00); // and-nor
        rchk(seq_pkg::CFG_OFS, 32'h000fef02); // lane merge
        clk_en <= 1'b0;
        din <= 4'h0;
        repeat (3) @(posedge clk);
        clk_en <= 1'b1;
        oe_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk(freg_oe, 4'hf); // pins driven again
        wreg(seq_pkg::TERM_BASE, 32'h00010000);
        chk(bio_out, 8'h02); // linked nor is low
        wreg(seq_pkg::CLINK_OFS, 32'hfffffffe);
        chk(bio_out, 8'h00); // nor of idle terms is high
        din <= 4'h2;
        repeat (2) @(posedge clk);
        chk(bio_out, 8'h02); // active term pulls nor low
        wrap_up();
    end
endmodule : test_programmable_jk_logic_sequencer
